// File: rtl/stx_tx_pcs.v
// transmit coding path: fifo, byte serializer, coder, serializer
`timescale 1ns/1ps
`include "stx_defs.vh"
module stx_tx_pcs #(
    parameter DEPTH = `STX_FIFO_DEPTH,
    parameter LOCK_CYC = `STX_LOCK_CYC
) (
    input wire core_clk,
    input wire rstn,
    input wire [19:0] tx_data,
    input wire [1:0] tx_ctrl,
    input wire tx_valid,
    output wire tx_ready,
    input wire cfg_double,
    input wire cfg_enc_en,
    input wire cfg_ten_bit,
    input wire cfg_proto,
    input wire cfg_gige_sm_dis,
    output reg tx_word_strobe_r,
    output reg tx_serial_r,
    output reg pll_locked_r
);
    // fifo side
    wire [21:0] fifo_out;
    wire fifo_valid;
    wire pop;

    // word timing
    reg [3:0] bit_cnt_r;
    wire [3:0] word_bits;
    wire tick;

    // byte serializer state
    reg half_r;
    reg [9:0] hold_r;
    reg hold_k_r;

    // current single width word
    reg [9:0] cur;
    reg cur_k;

    // protocol state
    reg [6:0] prbs_r;
    reg [4:0] a_cnt_r;
    reg gige_k_r;
    reg gige_pos_r;
    reg rd_r;

    // mapped byte for the encoder
    reg [7:0] enc_byte;
    reg enc_k;
    reg is_idle;
    wire [9:0] enc_code;
    wire enc_rd;
    reg [9:0] word;

    // serializer
    reg [9:0] sh_r;

    // lock timer
    reg [15:0] lock_cnt_r;

    // every user word crosses the fifo, no bypass path exists
    // the user paces writes on tx_ready, so writes can run ahead of the strobe until the fifo fills
    stx_phase_fifo #(
        .WIDTH(22),
        .DEPTH(DEPTH),
        .AW(2)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr_en(tx_valid),
        .wr_data({tx_ctrl, tx_data}),
        .wr_ready_r(tx_ready),
        .rd_en(pop),
        .rd_data(fifo_out),
        .rd_valid_r(fifo_valid)
    );

    // encoder works on the running disparity held here
    stx_enc8b10b u_enc (
        .din(enc_byte),
        .is_k(enc_k),
        .rd_in(rd_r),
        .code(enc_code),
        .rd_out(enc_rd)
    );

    // encoded or ten bit raw words are ten bits, else eight
    assign word_bits = (cfg_enc_en | cfg_ten_bit) ?
                       `STX_BITS_WIDE : `STX_BITS_NARROW;
    assign tick = (bit_cnt_r == word_bits - 4'd1);

    // a new user word is needed on every tick except upper halves
    assign pop = tick & fifo_valid & ~(cfg_double & half_r);

    // xgmii control character to xaui code group
    function [7:0] xaui_map;
        input [7:0] v;
        begin
            case (v)
                `STX_XG_SEQ: xaui_map = `STX_K28_4;
                `STX_XG_START: xaui_map = `STX_K27_7;
                `STX_XG_TERM: xaui_map = `STX_K29_7;
                `STX_XG_ERR: xaui_map = `STX_K30_7;
                default: xaui_map = `STX_K30_7;
            endcase
        end
    endfunction

    // select the single width word for this tick
    always @* begin
        cur = 10'h000;
        cur_k = 1'b1;
        if (cfg_double && half_r) begin
            cur = hold_r; // upper half follows lower
            cur_k = hold_k_r;
        end else if (fifo_valid) begin
            // lower half, or the whole word in single width
            if (cfg_enc_en || !cfg_ten_bit)
                cur = {2'b00, fifo_out[7:0]};
            else
                cur = fifo_out[9:0];
            cur_k = fifo_out[20];
        end else if (cfg_proto == `STX_PROTO_XAUI) begin
            cur = {2'b00, `STX_XG_IDLE}; // underrun fills idle
        end else begin
            cur = {2'b00, `STX_K28_5};
        end
    end

    // transmit state machine ahead of the encoder
    always @* begin
        enc_byte = cur[7:0];
        enc_k = cur_k;
        is_idle = 1'b0;
        if (cfg_proto == `STX_PROTO_XAUI) begin
            if (cur_k && cur[7:0] == `STX_XG_IDLE) begin
                is_idle = 1'b1;
                if (a_cnt_r == 5'd0)
                    enc_byte = `STX_K28_3;
                else if (prbs_r[0])
                    enc_byte = `STX_K28_5;
                else
                    enc_byte = `STX_K28_0;
            end else if (cur_k) begin
                enc_byte = xaui_map(cur[7:0]);
            end
        end else if (!cfg_gige_sm_dis) begin
            // second group of an idle set, configuration sets kept
            if (gige_k_r && !cur_k &&
                cur[7:0] != `STX_D21_5 &&
                cur[7:0] != `STX_D2_2) begin
                if (gige_pos_r)
                    enc_byte = `STX_D5_6;
                else
                    enc_byte = `STX_D16_2;
            end
        end
    end

    // encoded group, or the raw word when the encoder is bypassed
    always @* begin
        if (cfg_enc_en)
            word = enc_code;
        else
            word = cur;
    end

    // bit counter paces single width words
    always @(posedge core_clk) begin
        if (!rstn) begin
            bit_cnt_r <= 4'd0;
        end else if (tick) begin
            bit_cnt_r <= 4'd0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 4'd1;
        end
    end

    // byte serializer keeps the upper half for the next tick
    always @(posedge core_clk) begin
        if (!rstn) begin
            half_r <= 1'b0;
            hold_r <= 10'h000;
            hold_k_r <= 1'b0;
        end else if (tick) begin
            if (pop && cfg_double) begin
                half_r <= 1'b1;
                hold_k_r <= fifo_out[21];
                if (cfg_enc_en || !cfg_ten_bit)
                    hold_r <= {2'b00, fifo_out[15:8]};
                else
                    hold_r <= fifo_out[19:10];
            end else begin
                half_r <= 1'b0;
            end
        end
    end

    // running disparity advances only through the encoder
    always @(posedge core_clk) begin
        if (!rstn) begin
            rd_r <= 1'b0;
        end else if (tick && cfg_enc_en) begin
            rd_r <= enc_rd;
        end
    end

    // gige idle tracking: remember disparity ahead of K28.5
    always @(posedge core_clk) begin
        if (!rstn) begin
            gige_k_r <= 1'b0;
            gige_pos_r <= 1'b0;
        end else if (tick) begin
            gige_k_r <= cfg_enc_en && enc_k &&
                        enc_byte == `STX_K28_5 &&
                        cfg_proto == `STX_PROTO_GIGE;
            gige_pos_r <= rd_r;
        end
    end

    // xaui idle randomizer x^7+x^6+1, steps once per idle
    always @(posedge core_clk) begin
        if (!rstn) begin
            prbs_r <= `STX_PRBS_SEED;
        end else if (tick && cfg_enc_en && is_idle) begin
            prbs_r <= {prbs_r[5:0], prbs_r[6] ^ prbs_r[5]};
        end
    end

    // alignment spacing reloads to 16..31 after each K28.3
    always @(posedge core_clk) begin
        if (!rstn) begin
            a_cnt_r <= `STX_A_MIN;
        end else if (tick && cfg_enc_en && is_idle) begin
            if (a_cnt_r == 5'd0)
                a_cnt_r <= {1'b1, prbs_r[3:0]};
            else
                a_cnt_r <= a_cnt_r - 5'd1;
        end
    end

    // parallel to serial, least significant bit first
    always @(posedge core_clk) begin
        if (!rstn) begin
            sh_r <= 10'h000;
            tx_serial_r <= 1'b0;
        end else if (tick) begin
            sh_r <= word;
            tx_serial_r <= word[0];
        end else begin
            sh_r <= {1'b0, sh_r[9:1]};
            tx_serial_r <= sh_r[1];
        end
    end

    // user strobe marks each consumed user word
    always @(posedge core_clk) begin
        if (!rstn) begin
            tx_word_strobe_r <= 1'b0;
        end else begin
            tx_word_strobe_r <= pop;
        end
    end

    // lock status rises once the lock time has run after reset
    always @(posedge core_clk) begin
        if (!rstn) begin
            lock_cnt_r <= 16'h0000;
            pll_locked_r <= 1'b0;
        end else if (lock_cnt_r == LOCK_CYC[15:0]) begin
            pll_locked_r <= 1'b1;
        end else begin
            lock_cnt_r <= lock_cnt_r + 16'h0001;
        end
    end
endmodule

// File: rtl/stx_defs.vh
// constants for the serial transmit coding path
`ifndef STX_DEFS_VH
`define STX_DEFS_VH
// phase compensation fifo depth in words
`define STX_FIFO_DEPTH 4
// word sizes in bits
`define STX_BITS_WIDE 4'd10
`define STX_BITS_NARROW 4'd8
// protocol select codes
`define STX_PROTO_GIGE 1'b0
`define STX_PROTO_XAUI 1'b1
// special code groups as byte values with k set
`define STX_K28_0 8'h1c
`define STX_K28_3 8'h7c
`define STX_K28_4 8'h9c
`define STX_K28_5 8'hbc
`define STX_K27_7 8'hfb
`define STX_K29_7 8'hfd
`define STX_K30_7 8'hfe
// data code groups used by the ordered sets
`define STX_D5_6 8'hc5
`define STX_D16_2 8'h50
`define STX_D21_5 8'hb5
`define STX_D2_2 8'h42
// xgmii control characters
`define STX_XG_IDLE 8'h07
`define STX_XG_SEQ 8'h9c
`define STX_XG_START 8'hfb
`define STX_XG_TERM 8'hfd
`define STX_XG_ERR 8'hfe
// alignment spacing floor and prbs seed
`define STX_A_MIN 5'd16
`define STX_PRBS_SEED 7'h7f
// clock generator lock time
`define STX_CLK_NS 50
`define STX_LOCK_NS 1000
`define STX_LOCK_CYC ((`STX_LOCK_NS + `STX_CLK_NS - 1) / `STX_CLK_NS)
`endif

// File: rtl/stx_phase_fifo.v
// four entry phase compensation fifo between user and coding path
`timescale 1ns/1ps
module stx_phase_fifo #(
    parameter WIDTH = 22,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire core_clk,
    input wire rstn,
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    output reg wr_ready_r,
    input wire rd_en,
    output wire [WIDTH-1:0] rd_data,
    output reg rd_valid_r
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    reg [AW:0] cnt_nxt;
    wire do_wr;
    wire do_rd;

    // accept only while room, drain only while filled
    assign do_wr = wr_en & wr_ready_r;
    assign do_rd = rd_en & rd_valid_r;
    assign rd_data = mem[rp_r];

    // level after this cycle
    always @* begin
        cnt_nxt = cnt_r;
        if (do_wr & ~do_rd)
            cnt_nxt = cnt_r + 1'b1;
        else if (do_rd & ~do_wr)
            cnt_nxt = cnt_r - 1'b1;
    end

    // storage write
    always @(posedge core_clk) begin
        if (do_wr)
            mem[wp_r] <= wr_data;
    end

    // pointers and flags
    always @(posedge core_clk) begin
        if (!rstn) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            wr_ready_r <= 1'b1;
            rd_valid_r <= 1'b0;
        end else begin
            if (do_wr)
                wp_r <= wp_r + 1'b1;
            if (do_rd)
                rp_r <= rp_r + 1'b1;
            cnt_r <= cnt_nxt;
            wr_ready_r <= (cnt_nxt != DEPTH[AW:0]);
            rd_valid_r <= (cnt_nxt != {(AW+1){1'b0}});
        end
    end
endmodule

// File: rtl/stx_enc8b10b.v
// 8b/10b encoder with running disparity, bit 0 is sent first
`timescale 1ns/1ps
module stx_enc8b10b (
    input wire [7:0] din,
    input wire is_k,
    input wire rd_in,
    output reg [9:0] code,
    output reg rd_out
);
    reg [5:0] c6;
    reg [3:0] c4;
    reg rd_mid;
    reg unb6;
    reg unb4;
    reg alt7;
    wire [4:0] x;
    wire [2:0] y;

    assign x = din[4:0];
    assign y = din[7:5];

    // 5b/6b codes for negative disparity, a as msb
    function [5:0] tab6;
        input [4:0] v;
        begin
            case (v)
                5'd0: tab6 = 6'b100111;  5'd1: tab6 = 6'b011101;
                5'd2: tab6 = 6'b101101;  5'd3: tab6 = 6'b110001;
                5'd4: tab6 = 6'b110101;  5'd5: tab6 = 6'b101001;
                5'd6: tab6 = 6'b011001;  5'd7: tab6 = 6'b111000;
                5'd8: tab6 = 6'b111001;  5'd9: tab6 = 6'b100101;
                5'd10: tab6 = 6'b010101; 5'd11: tab6 = 6'b110100;
                5'd12: tab6 = 6'b001101; 5'd13: tab6 = 6'b101100;
                5'd14: tab6 = 6'b011100; 5'd15: tab6 = 6'b010111;
                5'd16: tab6 = 6'b011011; 5'd17: tab6 = 6'b100011;
                5'd18: tab6 = 6'b010011; 5'd19: tab6 = 6'b110010;
                5'd20: tab6 = 6'b001011; 5'd21: tab6 = 6'b101010;
                5'd22: tab6 = 6'b011010; 5'd23: tab6 = 6'b111010;
                5'd24: tab6 = 6'b110011; 5'd25: tab6 = 6'b100110;
                5'd26: tab6 = 6'b010110; 5'd27: tab6 = 6'b110110;
                5'd28: tab6 = 6'b001110; 5'd29: tab6 = 6'b101110;
                5'd30: tab6 = 6'b011110; default: tab6 = 6'b101011;
            endcase
        end
    endfunction

    // 3b/4b codes for negative disparity, f as msb
    function [3:0] tab4;
        input [2:0] v;
        begin
            case (v)
                3'd0: tab4 = 4'b1011; 3'd1: tab4 = 4'b1001;
                3'd2: tab4 = 4'b0101; 3'd3: tab4 = 4'b1100;
                3'd4: tab4 = 4'b1101; 3'd5: tab4 = 4'b1010;
                3'd6: tab4 = 4'b0110; default: tab4 = 4'b1110;
            endcase
        end
    endfunction

    // number of ones in a six bit group
    function [2:0] ones;
        input [5:0] v;
        begin
            ones = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]}
                 + {2'b00, v[3]} + {2'b00, v[4]} + {2'b00, v[5]};
        end
    endfunction

    // disparity control keeps run length at five or less
    always @* begin
        c6 = (is_k && x == 5'd28) ? 6'b001111 : tab6(x);
        unb6 = (ones(c6) != 3'd3);
        if (rd_in && (unb6 || x == 5'd7))
            c6 = ~c6;
        rd_mid = unb6 ? ~rd_in : rd_in;
        alt7 = (y == 3'd7) && (is_k ||
               (!rd_mid && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
               (rd_mid && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
        c4 = alt7 ? 4'b0111 : tab4(y);
        unb4 = (ones({2'b00, c4}) != 3'd2);
        if (is_k && !unb4 && y != 3'd3 && !rd_mid)
            c4 = ~c4;
        if (rd_mid && (unb4 || y == 3'd3))
            c4 = ~c4;
        rd_out = unb4 ? ~rd_mid : rd_mid;
        code = {c4[0], c4[1], c4[2], c4[3],
                c6[0], c6[1], c6[2], c6[3], c6[4], c6[5]};
    end
endmodule

// File: testbench/stx_tx_pcs_props.sv
// checker for the serial transmit coding path ports
`timescale 1ns/1ps
module stx_tx_pcs_chk #(
    parameter DEPTH = 4,
    parameter LOCK_CYC = 20
) (
    input wire core_clk,
    input wire rstn,
    input wire [19:0] tx_data,
    input wire [1:0] tx_ctrl,
    input wire tx_valid,
    input wire tx_ready,
    input wire cfg_double,
    input wire cfg_enc_en,
    input wire cfg_ten_bit,
    input wire cfg_proto,
    input wire cfg_gige_sm_dis,
    input wire tx_word_strobe_r,
    input wire tx_serial_r,
    input wire pll_locked_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic [7:0] age_r;
    logic [3:0] run_r;
    logic [3:0] pend_r;
    logic last_r;
    // cycles since release, equal-bit run, words taken but not yet sent
    always @(posedge core_clk) begin
        if (!rstn) begin
            age_r <= 8'h0;
            run_r <= 4'h1;
            pend_r <= 4'h0;
            last_r <= 1'b0;
        end else begin
            if (age_r != 8'hff)
                age_r <= age_r + 8'h1;
            if (tx_serial_r == last_r && run_r != 4'hf)
                run_r <= run_r + 4'h1;
            else
                run_r <= 4'h1;
            last_r <= tx_serial_r;
            pend_r <= pend_r + {3'h0, tx_valid & tx_ready}
                - {3'h0, tx_word_strobe_r};
        end
    end
    property p_reset_state;
        age_r == 8'h1 |-> tx_ready && !tx_word_strobe_r && !pll_locked_r;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("state after reset wrong");
    property p_lock;
        pll_locked_r == (age_r > LOCK_CYC);
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock status at wrong time");
    property p_strobe_gap;
        tx_word_strobe_r |=> !tx_word_strobe_r [*7];
    endproperty
    a_strobe_gap: assert property (p_strobe_gap)
        else $error("words closer than eight bits");
    property p_double_gap;
        cfg_double && tx_word_strobe_r
            |=> !tx_word_strobe_r [*8] ##1 !tx_word_strobe_r [*7];
    endproperty
    a_double_gap: assert property (p_double_gap)
        else $error("double word rate too fast");
    property p_run;
        cfg_enc_en && age_r > 8'd24 |-> run_r <= 4'd5;
    endproperty
    a_run: assert property (p_run)
        else $error("run of equal bits too long");
    property p_fill;
        $fell(tx_ready) |-> $past(tx_valid);
    endproperty
    a_fill: assert property (p_fill)
        else $error("ready fell without a write");
    property p_refill;
        !tx_ready |-> ##[1:24] tx_ready;
    endproperty
    a_refill: assert property (p_refill)
        else $error("fifo did not drain");
    property p_no_phantom;
        tx_word_strobe_r |-> pend_r != 4'h0;
    endproperty
    a_no_phantom: assert property (p_no_phantom)
        else $error("strobe without a stored word");
    property p_depth;
        pend_r <= DEPTH + 1;
    endproperty
    a_depth: assert property (p_depth)
        else $error("fifo held too many words");
endmodule

// File: testbench/stx_user_model.sv
// user logic model feeding words into the transmit path
`timescale 1ns/1ps
module stx_user_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic tx_ready,
    output logic [19:0] tx_data = 20'h0,
    output logic [1:0] tx_ctrl = 2'h0,
    output logic tx_valid = 1'b0
);
    logic [21:0] pend[$];
    task push(input logic [19:0] d, input logic [1:0] k);
        pend.push_back({k, d});
    endtask
    // same clock as the path; hold each word until the fifo takes it
    always @(posedge core_clk) begin
        if (!rstn) begin
            tx_valid <= 1'b0;
        end else if (!tx_valid || tx_ready) begin
            if (pend.size() != 0 && !(slow && tx_valid)) begin
                {tx_ctrl, tx_data} <= pend.pop_front();
                tx_valid <= 1'b1;
            end else begin
                tx_valid <= 1'b0;
                tx_data <= ~tx_data; // released lines lose the value
            end
        end
    end
endmodule

// File: testbench/stx_tx_pcs_bench.sv
// testbench for the serial transmit coding path
`timescale 1ns/1ps
module stx_tx_pcs_bench;
    localparam int LOCK = 3;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic slow = 1'b0;
    logic cfg_double = 1'b0;
    logic cfg_enc_en = 1'b0;
    logic cfg_ten_bit = 1'b0;
    logic cfg_proto = 1'b0;
    logic cfg_gige_sm_dis = 1'b0;
    logic [19:0] tx_data;
    logic [1:0] tx_ctrl;
    logic tx_valid, tx_ready, tx_word_strobe_r, tx_serial_r, pll_locked_r;
    int num_errors = 0;
    int num_checks = 0;
    int nbits = 8;
    int cyc = 0;
    int cap_i = -1;
    int i;
    int na;
    int gap;
    logic [19:0] got[$];
    logic [19:0] cap_w, k0, w;
    logic [7:0] xb[6] = '{8'h9c, 8'hfb, 8'hfd, 8'hfe, 8'h55, 8'h00};
    logic xk[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [9:0] xe[6] = '{10'h13c, 10'h05b, 10'h05d, 10'h05e, 10'h05e,
        10'h0b9};
    initial forever #25 core_clk = ~core_clk;
    stx_tx_pcs #(.LOCK_CYC(LOCK)) DUT (.core_clk(core_clk), .rstn(rstn),
        .tx_data(tx_data), .tx_ctrl(tx_ctrl), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .cfg_double(cfg_double),
        .cfg_enc_en(cfg_enc_en), .cfg_ten_bit(cfg_ten_bit),
        .cfg_proto(cfg_proto), .cfg_gige_sm_dis(cfg_gige_sm_dis),
        .tx_word_strobe_r(tx_word_strobe_r), .tx_serial_r(tx_serial_r),
        .pll_locked_r(pll_locked_r));
    stx_user_model u_user (.core_clk(core_clk), .rstn(rstn), .slow(slow),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_ctrl(tx_ctrl),
        .tx_valid(tx_valid));
    task report_and_stop();
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time,
                seen, exp);
        end
    endtask
    // either disparity form of a code group is accepted
    task check_rd(input logic [19:0] seen, input logic [9:0] neg);
        check(seen, (seen === {10'h0, ~neg}) ? seen : {10'h0, neg});
    endtask
    // gather the serial bits of each word announced by the strobe
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (tx_word_strobe_r === 1'b1) begin
            cap_i = 0;
            cap_w = 20'h0;
        end
        if (cap_i >= 0) begin
            cap_w[cap_i] = tx_serial_r;
            cap_i = cap_i + 1;
            if (cap_i == nbits) begin
                got.push_back(cap_w);
                cap_i = -1;
            end
        end
        if (cyc == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task setup(input logic dbl, enc, ten, proto, smdis, input int bits);
        @(posedge core_clk);
        rstn <= 1'b0;
        cfg_double <= dbl;
        cfg_enc_en <= enc;
        cfg_ten_bit <= ten;
        cfg_proto <= proto;
        cfg_gige_sm_dis <= smdis;
        nbits = bits;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        got.delete();
        cap_i = -1;
    endtask
    task wait_words(input int n);
        for (int t = 0; t < 800 && got.size() < n; t++)
            @(posedge core_clk);
    endtask
    function logic [19:0] take();
        return got.size() != 0 ? got.pop_front() : 20'hxxxxx;
    endfunction
    initial begin
        // raw narrow words, six back to back so the fifo fills
        setup(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8);
        check({tx_ready, tx_word_strobe_r, tx_serial_r, pll_locked_r},
            20'h8);
        // look at the lock flag between edges, where it has settled
        repeat (LOCK) @(posedge core_clk);
        @(negedge core_clk);
        check(pll_locked_r, 20'h0);
        @(negedge core_clk);
        check(pll_locked_r, 20'h1);
        for (i = 0; i < 6; i++)
            u_user.push(20'h3c5a9 + 20'(i * 4951), 2'h0);
        wait_words(6);
        for (i = 0; i < 6; i++)
            check(take(), (20'h3c5a9 + 20'(i * 4951)) & 20'hff);
        // raw double words at both widths, partner slow
        for (i = 0; i < 2; i++) begin
            setup(1'b1, 1'b0, i[0], 1'b0, 1'b0, i ? 20 : 16);
            slow <= 1'b1;
            u_user.push(20'h9c3a5, 2'h0);
            u_user.push(20'h1b6e7, 2'h0);
            wait_words(2);
            check(take(), 20'h9c3a5 & (i ? 20'hfffff : 20'h0ffff));
            check(take(), 20'h1b6e7 & (i ? 20'hfffff : 20'h0ffff));
            slow <= 1'b0;
        end
        // idle and configuration sets with substitution on
        setup(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 10);
        for (i = 0; i < 3; i++) begin
            u_user.push(20'hbc, 2'h1);
            u_user.push(i == 0 ? 20'h00 : (i == 1 ? 20'hb5 : 20'h42), 2'h0);
        end
        wait_words(6);
        for (i = 0; i < 3; i++) begin
            k0 = take();
            check_rd(k0, 10'h17c);
            w = take();
            if (i == 0)
                check(w, k0 === 20'h283 ? 20'h1a5 : 20'h289);
            else if (i == 1)
                check(w, 20'h155);
            else
                check(w, k0 === 20'h283 ? 20'h2ad : 20'h292);
        end
        // substitution disabled leaves the data byte as sent
        setup(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 10);
        u_user.push(20'hbc, 2'h1);
        u_user.push(20'h00, 2'h0);
        wait_words(2);
        k0 = take();
        check(take(), k0 === 20'h283 ? 20'h0b9 : 20'h346);
        // control character mapping and randomized idles
        setup(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 10);
        for (i = 0; i < 6; i++)
            u_user.push({12'h0, xb[i]}, {1'b0, xk[i]});
        for (i = 0; i < 46; i++)
            u_user.push(20'h07, 2'h1);
        wait_words(52);
        for (i = 0; i < 6; i++)
            check_rd(take(), xe[i]);
        for (i = 0; i < 6; i++) begin
            w = take();
            check({19'h0, w === 20'h0bc || w === 20'h343 || w === 20'h33c
                || w === 20'h0c3 || w === 20'h17c || w === 20'h283},
                20'h1);
        end
        // alignment groups in a long idle run, at least 16 idles apart
        na = 0;
        gap = 0;
        for (i = 0; i < 40; i++) begin
            w = take();
            if (w === 20'h33c || w === 20'h0c3) begin
                if (na > 0)
                    check({19'h0, gap >= 16}, 20'h1);
                na++;
                gap = 0;
            end else begin
                gap++;
            end
        end
        check({19'h0, na > 0}, 20'h1);
        report_and_stop();
    end
endmodule
bind stx_tx_pcs stx_tx_pcs_chk #(.DEPTH(DEPTH), .LOCK_CYC(LOCK_CYC)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .tx_data(tx_data),
    .tx_ctrl(tx_ctrl), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .cfg_double(cfg_double), .cfg_enc_en(cfg_enc_en),
    .cfg_ten_bit(cfg_ten_bit), .cfg_proto(cfg_proto),
    .cfg_gige_sm_dis(cfg_gige_sm_dis),
    .tx_word_strobe_r(tx_word_strobe_r), .tx_serial_r(tx_serial_r),
    .pll_locked_r(pll_locked_r));
